// *** hdl/serial_port_pkg.sv ***
`default_nettype none
package serial_port_pkg;
    // Wishbone register offsets (byte addresses)
    localparam logic [3:0] OFS_MODE = 4'h0;
    localparam logic [3:0] OFS_ASYNC = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_TXD = 4'hC;
    localparam logic [3:0] OFS_RXD = 4'h0;
    localparam logic [4:0] OFS_RXB = 5'h10;
    // Mode register fields
    localparam int MODE_CSIE = 0;
    localparam int MODE_TXE = 1;
    localparam int MODE_RXE = 2;
    localparam int MODE_HIZ = 3;
    localparam int MODE_TCL = 4;
    localparam logic [1:0] TCL_EXT = 2'h0;
    // Async mode fields
    localparam int AS_PAR = 0;
    localparam int AS_CL8 = 2;
    localparam int AS_SL2 = 3;
    localparam int AS_ISRM = 4;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;
    // Status fields
    localparam int ST_PE = 0;
    localparam int ST_FE = 1;
    localparam int ST_OVE = 2;
    localparam int ST_IRQ = 3;
    localparam int ST_BUSY = 4;
    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int BAUD_BPS = 9575;
    localparam int START_US = 52;
    localparam int BIT_CYC = CLK_HZ / BAUD_BPS;
    localparam int START_CYC = CLK_HZ / 1_000_000 * START_US;
    localparam int HALF_SCK_CYC = 2 * BIT_CYC / 16;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_7 = 4'h7;
    // Grouped configuration for the UART core
    typedef struct packed {
        logic [1:0] parity;
        logic len8;
        logic stop2;
    } uart_cfg_t;
endpackage
`default_nettype wire

// *** hdl/uart_rx.sv ***
`default_nettype none
module uart_rx
    import serial_port_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control
    input wire logic enable,
    input wire uart_cfg_t cfg,
    // Synchronised line
    input wire logic rxd,
    // Result
    output logic done,
    output logic [7:0] data,
    output logic perr,
    output logic ferr
);
    typedef enum logic [3:0] {
        R_IDLE = 4'b0001,
        R_START = 4'b0010,
        R_BITS = 4'b0100,
        R_STOP = 4'b1000
    } rstate_t;
    rstate_t st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [3:0] idx_r, idx_nxt;
    logic [8:0] sh_r, sh_nxt;
    logic done_r, done_nxt, perr_r, perr_nxt, ferr_r, ferr_nxt;
    logic [7:0] data_r, data_nxt;
    logic [3:0] nbits;

    // Character bits plus optional parity
    always_comb begin
        nbits = (cfg.len8 ? BITS_8 : BITS_7) + ((cfg.parity != PAR_NONE) ? 4'h1 : 4'h0);
    end

    // Receive sequencer; samples mid bit after a 52 us start qualification
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        idx_nxt = idx_r;
        sh_nxt = sh_r;
        done_nxt = 1'b0;
        perr_nxt = perr_r;
        ferr_nxt = ferr_r;
        data_nxt = data_r;
        case (st_r)
            R_IDLE: begin
                cnt_nxt = 16'h0000;
                if (enable && !rxd) begin
                    st_nxt = R_START;
                end
            end
            R_START: begin
                cnt_nxt = cnt_r + 16'h0001;
                if (rxd) begin
                    st_nxt = R_IDLE;
                end else if (cnt_r == 16'(START_CYC - 1)) begin
                    st_nxt = R_BITS;
                    cnt_nxt = 16'h0000;
                    idx_nxt = 4'h0;
                    sh_nxt = 9'h000;
                end
            end
            R_BITS: begin
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r == 16'(BIT_CYC - 1)) begin
                    cnt_nxt = 16'h0000;
                    // LSB first, parity after data
                    sh_nxt = {rxd, sh_r[8:1]};
                    idx_nxt = idx_r + 4'h1;
                    if (idx_r == nbits - 4'h1) begin
                        st_nxt = R_STOP;
                    end
                end
            end
            R_STOP: begin
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r == 16'(BIT_CYC - 1)) begin
                    st_nxt = R_IDLE;
                    done_nxt = 1'b1;
                    ferr_nxt = !rxd;
                    // Align by frame length: shift register holds nbits in top
                    data_nxt = 8'(({sh_r, 9'h000} >> (5'd18 - {1'b0, nbits})));
                    if (!cfg.len8) begin
                        data_nxt[7] = 1'b0;
                    end
                    perr_nxt = 1'b0;
                    if (cfg.parity == PAR_EVEN || cfg.parity == PAR_ODD) begin
                        // Parity bit lands at index nbits-1 of aligned frame
                        perr_nxt = (^(18'({sh_r, 9'h000} >> (5'd18 - {1'b0, nbits}))))
                            ^ (cfg.parity == PAR_ODD);
                    end
                end
            end
            default: st_nxt = R_IDLE;
        endcase
        if (!enable) begin
            st_nxt = R_IDLE;
        end
    end

    // Receive registers
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= R_IDLE;
            cnt_r <= 16'h0000;
            idx_r <= 4'h0;
            sh_r <= 9'h000;
            done_r <= 1'b0;
            perr_r <= 1'b0;
            ferr_r <= 1'b0;
            data_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            idx_r <= idx_nxt;
            sh_r <= sh_nxt;
            done_r <= done_nxt;
            perr_r <= perr_nxt;
            ferr_r <= ferr_nxt;
            data_r <= data_nxt;
        end
    end

    assign done = done_r;
    assign data = data_r;
    assign perr = perr_r;
    assign ferr = ferr_r;
endmodule
`default_nettype wire

// *** hdl/dual_mode_serial_port.sv ***
// Overview of operation
// - Clocked mode shifts data out MSB first, changing on falling clock edges.
// - Clocked mode samples input on rising clock edges into the low end.
// - Master transfer starts when software writes the transmit register.
// - Slave leaves clock pin undriven; external master supplies the clock.
// - Interrupt flag set on the eighth rising clock edge of a transfer.
// - Master stops clock after eighth rising edge, holds it high.
// - Output drive flag set makes data pin driven, idling high.
// - Two-bit clock select picks internal clock out or external clock in.
// - Each clocked transfer moves 8 bits out and 8 bits into receive buffer.
// - UART transmit and receive run independently, full duplex.
// - UART rate fixed at 9575 bps from internal clock; far end matches.
// - UART transmit pin high when not transmitting.
// - Transmitter sends 7 or 8 bits with start, parity and stop bits.
// - Receiver captures 7 or 8 bits, detects parity, framing, overrun errors.
// - UART transmission starts when software writes the transmit register.
// - Start bit accepted only if line still low about 52 us later.
// - UART raises interrupt flag on transmit or receive completion.
// - Even, odd, zero or no parity generated; receiver checks even and odd parity only.
// - Reading the receive buffer clears the async status register.
// - Error mask set suppresses receive-complete interrupt on reception errors.
// - Seven-bit length ignores transmit bit 7, receive bit 7 reads zero.
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`default_nettype none
module dual_mode_serial_port
    import serial_port_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [4:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // Serial clock pin, two-way
    input wire logic SCLK_I,
    output logic SCLK_O,
    output logic SCLK_OE,
    // Serial data pins (shared with UART)
    input wire logic SIN_I,
    output logic SOUT_O,
    output logic SOUT_OE,
    // Interrupt request flag level
    output logic SERIAL_IRQ_FLAG
);
    typedef enum logic [2:0] {
        C_IDLE = 3'b001,
        C_LOW = 3'b010,
        C_HIGH = 3'b100
    } cstate_t;
    typedef enum logic [2:0] {
        T_IDLE = 3'b001,
        T_SHIFT = 3'b010,
        T_STOP = 3'b100
    } tstate_t;

    // Pin synchronisers: first stage feeds only the second
    logic [1:0] sck_s1_r, sck_s2_r, si_s1_r, si_s2_r;
    logic sck_d_r;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sck_s1_r <= 2'b11;
            sck_s2_r <= 2'b11;
            si_s1_r <= 2'b11;
            si_s2_r <= 2'b11;
            sck_d_r <= 1'b1;
        end else begin
            sck_s1_r <= {1'b0, SCLK_I};
            sck_s2_r <= sck_s1_r;
            si_s1_r <= {1'b0, SIN_I};
            si_s2_r <= si_s1_r;
            sck_d_r <= sck_s2_r[0];
        end
    end
    logic sck_sync, si_sync;
    assign sck_sync = sck_s2_r[0];
    assign si_sync = si_s2_r[0];

    // Register state
    logic [7:0] mode_r, mode_nxt, async_r, async_nxt, tx_r, tx_nxt, rxb_r, rxb_nxt;
    logic [2:0] st_r, st_nxt;
    logic irq_r, irq_nxt, ack_r, ack_nxt, rx_full_r, rx_full_nxt;
    logic [31:0] dat_r, dat_nxt;
    // Clocked-mode state
    cstate_t cs_r, cs_nxt;
    logic [7:0] csh_r, csh_nxt;
    logic [3:0] ccnt_r, ccnt_nxt;
    logic [15:0] cdiv_r, cdiv_nxt;
    logic sck_out_r, sck_out_nxt, so_r, so_nxt;
    // UART transmit state
    tstate_t ts_r, ts_nxt;
    logic [10:0] tsh_r, tsh_nxt;
    logic [3:0] tcnt_r, tcnt_nxt;
    logic [15:0] tdiv_r, tdiv_nxt;

    logic csie, txe, rxe, master, wr, rd;
    uart_cfg_t cfg;
    logic rx_done, rx_perr, rx_ferr;
    logic [7:0] rx_data;
    logic tx_par;
    logic [3:0] tx_bits;
    logic cs_fall, cs_rise, cs_in, cs_done;
    always_comb begin
        csie = mode_r[MODE_CSIE];
        txe = mode_r[MODE_TXE] && !csie;
        rxe = mode_r[MODE_RXE] && !csie;
        master = mode_r[MODE_TCL+1 -: 2] != TCL_EXT;
        cfg.parity = async_r[AS_PAR+1 -: 2];
        cfg.len8 = async_r[AS_CL8];
        cfg.stop2 = async_r[AS_SL2];
        wr = CYC_I && STB_I && WE_I && SEL_I[0] && !ack_r;
        rd = CYC_I && STB_I && !WE_I && !ack_r;
    end

    uart_rx u_rx (
        .clk(CLK),
        .srst(SRST),
        .enable(rxe),
        .cfg(cfg),
        .rxd(si_sync),
        .done(rx_done),
        .data(rx_data),
        .perr(rx_perr),
        .ferr(rx_ferr)
    );

    // Wishbone decode, registers, status and interrupt flag
    always_comb begin
        mode_nxt = mode_r;
        async_nxt = async_r;
        tx_nxt = tx_r;
        rxb_nxt = rxb_r;
        st_nxt = st_r;
        irq_nxt = irq_r;
        rx_full_nxt = rx_full_r;
        ack_nxt = CYC_I && STB_I && !ack_r;
        dat_nxt = 32'h0000_0000;
        if (rd) begin
            case (ADR_I)
                {1'b0, OFS_MODE}: dat_nxt = {24'h00_0000, mode_r};
                {1'b0, OFS_ASYNC}: dat_nxt = {24'h00_0000, async_r};
                {1'b0, OFS_STATUS}: dat_nxt = {27'h000_0000, ts_r != T_IDLE, irq_r, st_r};
                {1'b0, OFS_TXD}: dat_nxt = {24'h00_0000, tx_r};
                OFS_RXB: begin
                    dat_nxt = {24'h00_0000, rxb_r};
                    st_nxt = 3'b000;
                    rx_full_nxt = 1'b0;
                end
                default: dat_nxt = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            case (ADR_I)
                {1'b0, OFS_MODE}: mode_nxt = DAT_I[7:0];
                {1'b0, OFS_ASYNC}: async_nxt = DAT_I[7:0];
                {1'b0, OFS_STATUS}: irq_nxt = irq_r && !DAT_I[ST_IRQ];
                {1'b0, OFS_TXD}: tx_nxt = DAT_I[7:0];
                default: ;
            endcase
        end
        // Hardware events win over software clear
        if (cs_r == C_LOW && cdiv_r == 16'h0000 && ccnt_r == BITS_8 - 4'h1 && master) begin
            irq_nxt = 1'b1;
        end
        if (csie && !master && !sck_d_r && sck_sync && ccnt_r == BITS_8 - 4'h1) begin
            irq_nxt = 1'b1;
        end
        if (cs_done) begin
            rxb_nxt = {csh_r[6:0], cs_in};
        end
        if (ts_r == T_STOP && tdiv_r == 16'h0000 && tcnt_r == 4'h0) begin
            irq_nxt = 1'b1;
        end
        if (rx_done) begin
            rxb_nxt = rx_data;
            rx_full_nxt = 1'b1;
            st_nxt = {rx_full_r, rx_ferr, rx_perr};
            if (!(async_r[AS_ISRM] && (rx_full_r || rx_ferr || rx_perr))) begin
                irq_nxt = 1'b1;
            end
        end
    end

    // Clocked mode: master divides CLK, slave follows synchronised pin edges
    always_comb begin
        cs_in = si_sync;
        cs_fall = master ? (cs_r == C_HIGH && cdiv_r == 16'h0000)
                         : (sck_d_r && !sck_sync);
        cs_rise = master ? (cs_r == C_LOW && cdiv_r == 16'h0000)
                         : (!sck_d_r && sck_sync);
        cs_done = csie && cs_rise && ccnt_r == BITS_8 - 4'h1 && cs_r != C_IDLE;
    end
    always_comb begin
        cs_nxt = cs_r;
        csh_nxt = csh_r;
        ccnt_nxt = ccnt_r;
        cdiv_nxt = (cdiv_r == 16'h0000) ? 16'(HALF_SCK_CYC - 1) : cdiv_r - 16'h0001;
        sck_out_nxt = sck_out_r;
        so_nxt = so_r;
        case (cs_r)
            C_IDLE: begin
                sck_out_nxt = 1'b1;
                ccnt_nxt = 4'h0;
                cdiv_nxt = 16'(HALF_SCK_CYC - 1);
                if (csie && wr && ADR_I == {1'b0, OFS_TXD}) begin
                    csh_nxt = DAT_I[7:0];
                    cs_nxt = master ? C_HIGH : C_LOW;
                    cdiv_nxt = 16'h0000;
                end
            end
            C_HIGH, C_LOW: begin
                if (cs_fall) begin
                    so_nxt = csh_r[7];
                    if (master) begin
                        sck_out_nxt = 1'b0;
                        cs_nxt = C_LOW;
                    end
                end
                if (cs_rise) begin
                    csh_nxt = {csh_r[6:0], cs_in};
                    ccnt_nxt = ccnt_r + 4'h1;
                    if (master) begin
                        sck_out_nxt = 1'b1;
                        cs_nxt = C_HIGH;
                    end
                    if (ccnt_r == BITS_8 - 4'h1) begin
                        cs_nxt = C_IDLE;
                    end
                end
            end
            default: cs_nxt = C_IDLE;
        endcase
        if (!csie) begin
            cs_nxt = C_IDLE;
            so_nxt = 1'b1;
        end else if (cs_r == C_IDLE && !(wr && ADR_I == {1'b0, OFS_TXD})) begin
            so_nxt = 1'b1;
        end
    end

    // UART transmit: frame built LSB first, shifted at the fixed bit rate
    always_comb begin
        tx_par = ^(tx_r & (cfg.len8 ? 8'hFF : 8'h7F));
        tx_bits = (cfg.len8 ? BITS_8 : BITS_7) + ((cfg.parity != PAR_NONE) ? 4'h1 : 4'h0);
        ts_nxt = ts_r;
        tsh_nxt = tsh_r;
        tcnt_nxt = tcnt_r;
        tdiv_nxt = (tdiv_r == 16'h0000) ? 16'(BIT_CYC - 1) : tdiv_r - 16'h0001;
        case (ts_r)
            T_IDLE: begin
                tsh_nxt = 11'h7FF;
                if (txe && wr && ADR_I == {1'b0, OFS_TXD}) begin
                    ts_nxt = T_SHIFT;
                    tdiv_nxt = 16'(BIT_CYC - 1);
                    tcnt_nxt = tx_bits;
                    tsh_nxt = {2'b11, DAT_I[7:0], 1'b0};
                    if (!cfg.len8) begin
                        tsh_nxt[8] = 1'b1;
                    end
                end
            end
            T_SHIFT: begin
                if (tdiv_r == 16'h0000) begin
                    tsh_nxt = {1'b1, tsh_r[10:1]};
                    tcnt_nxt = tcnt_r - 4'h1;
                    // Insert parity after the last character bit
                    if (cfg.parity != PAR_NONE && tcnt_r == 4'h1) begin
                        case (cfg.parity)
                            PAR_EVEN: tsh_nxt[0] = tx_par;
                            PAR_ODD: tsh_nxt[0] = !tx_par;
                            default: tsh_nxt[0] = 1'b0;
                        endcase
                    end
                    if (tcnt_r == 4'h0) begin
                        ts_nxt = T_STOP;
                        tsh_nxt = 11'h7FF;
                        tcnt_nxt = cfg.stop2 ? 4'h1 : 4'h0;
                    end
                end
            end
            T_STOP: begin
                if (tdiv_r == 16'h0000) begin
                    tcnt_nxt = tcnt_r - 4'h1;
                    if (tcnt_r == 4'h0) begin
                        ts_nxt = T_IDLE;
                    end
                end
            end
            default: ts_nxt = T_IDLE;
        endcase
        if (!txe) begin
            ts_nxt = T_IDLE;
        end
    end

    // State registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            mode_r <= 8'h00;
            async_r <= 8'h00;
            tx_r <= 8'h00;
            rxb_r <= 8'h00;
            st_r <= 3'b000;
            irq_r <= 1'b0;
            rx_full_r <= 1'b0;
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
            cs_r <= C_IDLE;
            csh_r <= 8'h00;
            ccnt_r <= 4'h0;
            cdiv_r <= 16'h0000;
            sck_out_r <= 1'b1;
            so_r <= 1'b1;
            ts_r <= T_IDLE;
            tsh_r <= 11'h7FF;
            tcnt_r <= 4'h0;
            tdiv_r <= 16'h0000;
        end else begin
            mode_r <= mode_nxt;
            async_r <= async_nxt;
            tx_r <= tx_nxt;
            rxb_r <= rxb_nxt;
            st_r <= st_nxt;
            irq_r <= irq_nxt;
            rx_full_r <= rx_full_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            cs_r <= cs_nxt;
            csh_r <= csh_nxt;
            ccnt_r <= ccnt_nxt;
            cdiv_r <= cdiv_nxt;
            sck_out_r <= sck_out_nxt;
            so_r <= so_nxt;
            ts_r <= ts_nxt;
            tsh_r <= tsh_nxt;
            tcnt_r <= tcnt_nxt;
            tdiv_r <= tdiv_nxt;
        end
    end

    // Pin drive; clock pin released in slave mode
    always_comb begin
        SCLK_O = sck_out_r;
        SCLK_OE = csie && master;
        SOUT_O = csie ? so_r : tsh_r[0];
        SOUT_OE = mode_r[MODE_HIZ] || txe;
        DAT_O = dat_r;
        ACK_O = ack_r;
        SERIAL_IRQ_FLAG = irq_r;
    end
endmodule
`default_nettype wire

// *** verification/serial_port_assertions.sv ***
`default_nettype none
module serial_port_assertions
    import serial_port_pkg::*;
(
    // Clock, reset and bus
    input wire logic CLK,
    input wire logic SRST,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [4:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic ACK_O,
    // Pins
    input wire logic SCLK_O,
    input wire logic SCLK_OE,
    input wire logic SOUT_O,
    input wire logic SOUT_OE,
    input wire logic SERIAL_IRQ_FLAG
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mode_r;
    logic [7:0] mode_nxt;
    logic wr_hit;
    logic master_m;
    logic slave_m;
    // Shadow of the mode register, snooped at the taking edge like the real one
    assign wr_hit = !ACK_O && CYC_I && STB_I && WE_I && SEL_I[0];
    always_comb begin
        mode_nxt = mode_r;
        if (wr_hit && ADR_I == 5'(OFS_MODE)) begin
            mode_nxt = DAT_I[7:0];
        end
    end
    always_ff @(posedge CLK) begin
        mode_r <= SRST ? 8'h00 : mode_nxt;
    end
    assign master_m = mode_r[MODE_CSIE] && mode_r[5:4] != TCL_EXT;
    assign slave_m = mode_r[MODE_CSIE] && mode_r[5:4] == TCL_EXT;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    a_ack_single: assert property (ACK_O |=> !ACK_O)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("bus request not answered next cycle");
    // Two cycles of a mode before the pin enables are judged
    a_slave_hiz: assert property (slave_m ##1 slave_m |-> !SCLK_OE)
        else $error("clock pin driven in slave mode");
    a_master_drive: assert property (master_m ##1 master_m |-> SCLK_OE)
        else $error("clock pin not driven in master mode");
    a_out_drive: assert property (mode_r[MODE_HIZ] ##1 mode_r[MODE_HIZ] |-> SOUT_OE)
        else $error("data out not driven with drive flag set");
    a_out_rise: assert property (SCLK_OE && $rose(SCLK_O) |-> $stable(SOUT_O))
        else $error("data out moved on rising clock");
    a_irq_eighth: assert property (master_m && $rose(SERIAL_IRQ_FLAG) |->
        SCLK_O && !$past(SCLK_O, 3))
        else $error("flag not raised at a rising clock");
    a_clk_parked: assert property (master_m && SERIAL_IRQ_FLAG |-> SCLK_O)
        else $error("clock not parked high after transfer");
    a_start_write: assert property (master_m && wr_hit && ADR_I == 5'(OFS_TXD) |->
        ##[1:60] $fell(SCLK_O))
        else $error("write did not start a transfer");
    c_master: cover property (master_m && $rose(SERIAL_IRQ_FLAG));
    c_slave: cover property (slave_m && $rose(SERIAL_IRQ_FLAG));
    c_uart: cover property (!mode_r[MODE_CSIE] && $rose(SERIAL_IRQ_FLAG));
endmodule
bind dual_mode_serial_port serial_port_assertions chk_u (.CLK(CLK), .SRST(SRST),
    .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
    .DAT_I(DAT_I), .ACK_O(ACK_O), .SCLK_O(SCLK_O), .SCLK_OE(SCLK_OE),
    .SOUT_O(SOUT_O), .SOUT_OE(SOUT_OE), .SERIAL_IRQ_FLAG(SERIAL_IRQ_FLAG));
`default_nettype wire

// *** verification/link_partner.sv ***
`default_nettype none
module link_partner
    import serial_port_pkg::*;
(
    // Clock and observed lines
    input wire logic clk,
    input wire logic sclk,
    input wire logic sout,
    // Lines toward the device
    output logic sclk_drv,
    output logic sin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] tx_sh = 8'h00;
    logic [7:0] rx_sh = 8'h00;
    logic csi_bit = 1'b1;
    logic uart_bit = 1'b1;
    // Both roles idle high, so AND merges them onto one line
    assign sin = csi_bit & uart_bit;
    initial sclk_drv = 1'b1;
    // Clocked role: MSB out on falling, sample on rising
    always @(negedge sclk) begin
        csi_bit <= tx_sh[7];
        tx_sh <= {tx_sh[6:0], 1'b1};
    end
    always @(posedge sclk) begin
        rx_sh <= {rx_sh[6:0], sout};
    end
    task automatic load(input logic [7:0] d);
        tx_sh = d;
        csi_bit = 1'b1;
    endtask
    // Far master: eight clocks only, line stands still otherwise
    task automatic clock_out();
        #7;
        repeat (8) begin
            #80 sclk_drv = 1'b0;
            #80 sclk_drv = 1'b1;
        end
    endtask
    // Drive the UART line to b for n clock cycles
    task automatic hold(input logic b, input int n);
        uart_bit <= b;
        repeat (n) @(posedge clk);
    endtask
    task automatic uart_send(input logic [7:0] d, input int n, input logic par);
        hold(1'b0, BIT_CYC);
        for (int i = 0; i < n; i++) begin
            hold(d[i], BIT_CYC);
        end
        hold(par, BIT_CYC);
        hold(1'b1, BIT_CYC);
    endtask
    // Samples mid-bit, so a small rate skew is tolerated
    task automatic uart_recv(input int n, output logic [7:0] d, output logic par,
        output logic stp);
        d = 8'h00;
        @(negedge sout);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            d[i] = sout;
        end
        repeat (BIT_CYC) @(posedge clk);
        par = sout;
        repeat (BIT_CYC) @(posedge clk);
        stp = sout;
    endtask
endmodule
`default_nettype wire

// *** verification/tb_dual_mode_serial_port.sv ***
`default_nettype none
module tb_dual_mode_serial_port
    import serial_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] IRQB = 8'h01 << ST_IRQ;
    localparam logic [7:0] M_MST = 8'(1 << MODE_CSIE | 1 << MODE_HIZ | 1 << MODE_TCL);
    localparam logic [7:0] M_SLV = 8'(1 << MODE_CSIE | 1 << MODE_HIZ);
    localparam logic [7:0] M_UART = 8'(1 << MODE_TXE | 1 << MODE_RXE);
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic CYC_I = 1'b0;
    logic STB_I = 1'b0;
    logic WE_I = 1'b0;
    logic [4:0] ADR_I = 5'h00;
    logic [3:0] SEL_I = 4'hF;
    logic [31:0] DAT_I = 32'h0000_0000;
    logic [31:0] DAT_O;
    logic ACK_O, SCLK_O, SCLK_OE, SOUT_O, SOUT_OE, SERIAL_IRQ_FLAG;
    logic pclk, sin_w, sclk_w, sout_w;
    logic [7:0] gd;
    logic gp, gs;
    int miscompares = 0;
    int n_checks = 0;
    // Released clock line follows the partner's drive; released data line shows the inverse
    assign sclk_w = SCLK_OE ? SCLK_O : pclk;
    assign sout_w = SOUT_OE ? SOUT_O : ~SOUT_O;
    always #10 CLK = ~CLK;
    dual_mode_serial_port dut_u (.CLK(CLK), .SRST(SRST), .CYC_I(CYC_I), .STB_I(STB_I),
        .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
        .ACK_O(ACK_O), .SCLK_I(sclk_w), .SCLK_O(SCLK_O), .SCLK_OE(SCLK_OE),
        .SIN_I(sin_w), .SOUT_O(SOUT_O), .SOUT_OE(SOUT_OE),
        .SERIAL_IRQ_FLAG(SERIAL_IRQ_FLAG));
    link_partner lp_u (.clk(CLK), .sclk(sclk_w), .sout(sout_w), .sclk_drv(pclk),
        .sin(sin_w));
    task automatic tally_and_finish();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic [4:0] a, input logic w, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge CLK);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= w;
        ADR_I <= a;
        DAT_I <= {24'h00_0000, d};
        do @(posedge CLK); while (ACK_O !== 1'b1);
        q = DAT_O[7:0];
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(a, 1'b1, d, q);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] q;
        wb(a, 1'b0, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic wait_irq();
        while (SERIAL_IRQ_FLAG !== 1'b1) @(posedge CLK);
    endtask
    // Watchdog well above the longest frame pair
    initial begin
        #2_000_000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge CLK);
        chk({SCLK_O, SCLK_OE, SOUT_O, SOUT_OE, SERIAL_IRQ_FLAG, ACK_O, 2'b00}, 8'hA0);
        SRST <= 1'b0;
        rdc(5'h1C, 8'h00);
        $display("test reset done");
        // Master transfer, async enables left clear
        lp_u.load(8'h3C);
        wr(5'(OFS_MODE), M_MST);
        wr(5'(OFS_TXD), 8'hA5);
        wait_irq();
        chk(lp_u.rx_sh, 8'hA5);
        rdc(OFS_RXB, 8'h3C);
        chk({7'h00, SCLK_O}, 8'h01);
        wr(5'(OFS_STATUS), IRQB);
        $display("test master done");
        // Slave transfer clocked by the far side
        lp_u.load(8'h4B);
        wr(5'(OFS_MODE), M_SLV);
        wr(5'(OFS_TXD), 8'h96);
        chk({7'h00, SCLK_OE}, 8'h00);
        lp_u.clock_out();
        wait_irq();
        chk(lp_u.rx_sh, 8'h96);
        rdc(OFS_RXB, 8'h4B);
        wr(5'(OFS_STATUS), IRQB);
        $display("test slave done");
        // Full duplex, 7 bits odd parity, short glitch, bad parity in
        wr(5'(OFS_ASYNC), 8'(PAR_ODD));
        wr(5'(OFS_MODE), M_UART);
        fork
            begin
                lp_u.hold(1'b0, 1000);
                lp_u.hold(1'b1, 3000);
                lp_u.uart_send(8'h2D, 7, 1'b0);
            end
            lp_u.uart_recv(7, gd, gp, gs);
            wr(5'(OFS_TXD), 8'hD3);
        join
        repeat (BIT_CYC) @(posedge CLK);
        chk(gd, 8'h53);
        chk({6'h00, gp, gs}, {6'h00, ~^7'h53, 1'b1});
        rdc(5'(OFS_STATUS), 8'h01 << ST_PE | IRQB);
        rdc(OFS_RXB, 8'h2D);
        rdc(5'(OFS_STATUS), IRQB);
        chk({6'h00, SOUT_O, SOUT_OE}, 8'h03);
        $display("test uart done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
